/* File: design/fmo_defs.vh */
/*
 * Constants for the emergency run override block: register offsets,
 * field positions, reset values, mode codes and timing figures.
 * Assumes inclusion by bare name from design files of this block.
 */
`ifndef FMO_DEFS_VH
`define FMO_DEFS_VH

// Register word indexes, taken from the byte address bits below
`define FMO_REG_MODE      4'h0
`define FMO_REG_FREQ      4'h1
`define FMO_REG_DIR       4'h2
`define FMO_REG_COUNT     4'h3
`define FMO_REG_FUNC      4'h4
`define FMO_REG_RAMP      4'h5
`define FMO_REG_WAIT      4'h6
`define FMO_REG_STATUS    4'h7
`define FMO_ADDR_LSB      2
`define FMO_ADDR_MSB      5

// Mode selector codes
`define FMO_MODE_OFF      2'h0
`define FMO_MODE_TEST     2'h1
`define FMO_MODE_FULL     2'h2

// Terminal function code for emergency run
`define FMO_FUNC_EMERG    6'h33
`define FMO_FUNC_MAX      6'h34
`define FMO_NUM_TERM      5

// Frequency setting range and direction
`define FMO_FREQ_MAX      6'h3c
`define FMO_FREQ_RST      6'h00
`define FMO_DIR_RST       1'b0

// Ramp step and restart wait reset values; a ramp step takes the setting plus one cycles
`define FMO_RAMP_RST      16'h0010
`define FMO_WAIT_RST      16'h0028

// Trip vector bit positions
`define FMO_TRIP_W        16
`define FMO_MINOR_MASK    16'h0fff
`define FMO_MAJOR_MASK    16'h3000
`define FMO_CRIT_MASK     16'hc000

`endif

/* File: design/fmo_down_counter.v */
/*
 * Loadable down counter used for ramp stepping and restart waiting.
 * Assumes a common clock, asynchronous reset and clock enable.
 */
`timescale 1ns/1ps
module fmo_down_counter #(
  parameter W = 16
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  input  wire         load_i,
  input  wire [W-1:0] value_i,
  output wire         zero_o
);
  reg [W-1:0] cnt_ff;
  reg [W-1:0] nxt_cnt;

  // Load wins over counting, stop at zero
  always @* begin
    nxt_cnt = cnt_ff;
    if (load_i)
      nxt_cnt = value_i;
    else if (cnt_ff != {W{1'b0}})
      nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      cnt_ff <= {W{1'b0}};
    else if (ce_i)
      cnt_ff <= nxt_cnt;
  end

  assign zero_o = (cnt_ff == {W{1'b0}});
endmodule

/* File: design/fmo_fire_override.v */
/*
 * Emergency run override controller for a motor drive, with a
 * classic Wishbone register slave. Trips arrive as a level vector from
 * the fault detection logic; the block drives the frequency reference,
 * direction, run, trip relay and fault reset/restart requests.
 * Assumes all inputs synchronous to SYS_CLK_I.
 */
`timescale 1ns/1ps
`include "fmo_defs.vh"

// Behaviour
// - Emergency run starts only with mode at full or test value and a terminal coded for emergency asserted.
// - Each full emergency run raises the operation counter by one.
// - In test mode the run happens without auto restart and without counting.
// - During emergency run the emergency frequency overrides jog, multi-step and keypad sources.
// - Emergency run ramps up and down with the acceleration time, and down with the deceleration time after terminal release.
// - Emergency run stops when the emergency terminal is released.
// - Ignored trips are still logged but the trip relay stays inactive.
// - Minor trips such as external, safety stop, undervoltage and overheat are ignored.
// - Overvoltage, level one overcurrent and ground fault cause repeated reset and restart.
// - Successive restart attempts are spaced by the restart wait time.
// - Hardware diagnostic or arm-short overcurrent stops the drive even in emergency run.
// - The run direction setting accepts only two values.
// - The operation counter is read only and ignores writes.
// - Emergency restarts ignore the normal restart attempt limit.
module fmo_fire_override (
  input  wire                    SYS_CLK_I,
  input  wire                    RST_I,
  input  wire                    CE_I,
  input  wire [31:0]             ADR_I,
  input  wire [31:0]             DAT_I,
  output reg  [31:0]             DAT_O,
  input  wire                    WE_I,
  input  wire [3:0]              SEL_I,
  input  wire                    STB_I,
  input  wire                    CYC_I,
  output reg                     ACK_O,
  input  wire [4:0]              TERM_IN_I,
  input  wire [5:0]              NORMAL_FREQ_I,
  input  wire                    NORMAL_RUN_I,
  input  wire [`FMO_TRIP_W-1:0]  TRIP_I,
  output reg  [5:0]              FREQ_REF_O,
  output reg                     DIR_O,
  output reg                     RUN_O,
  output reg                     TRIP_RELAY_O,
  output reg                     TRIP_LOG_O,
  output reg                     FAULT_RESET_O,
  output reg                     EMERG_ACTIVE_O
);
  // States of the run sequencer
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_RUN   = 5'h02;
  localparam [4:0] ST_WAIT  = 5'h04;
  localparam [4:0] ST_STOP  = 5'h08;
  localparam [4:0] ST_RAMPD = 5'h10;

  reg  [1:0]   mode_ff;
  reg  [5:0]   freq_set_ff;
  reg          dir_set_ff;
  reg  [31:0]  count_ff;
  reg  [29:0]  func_ff;
  reg  [15:0]  accel_time_ff;
  reg  [15:0]  decel_time_ff;
  reg  [15:0]  restart_wait_time_ff;
  reg  [4:0]   state_ff;
  reg  [4:0]   nxt_state;
  reg  [5:0]   ramp_freq_ff;
  reg  [5:0]   nxt_ramp_freq;
  reg          armed_ff;
  reg  [`FMO_TRIP_W-1:0] trip_prev_ff;
  reg  [31:0]  nxt_rd;
  reg          term_hit;
  integer      k;

  wire [3:0]   reg_idx = ADR_I[`FMO_ADDR_MSB:`FMO_ADDR_LSB];
  wire         wr_req  = CYC_I & STB_I & WE_I & ~ACK_O;
  wire         sel_full = (mode_ff == `FMO_MODE_FULL);
  wire         sel_test = (mode_ff == `FMO_MODE_TEST);
  wire         minor   = |(TRIP_I & `FMO_MINOR_MASK);
  wire         major   = |(TRIP_I & `FMO_MAJOR_MASK);
  wire         crit    = |(TRIP_I & `FMO_CRIT_MASK);
  wire         new_trip = |(TRIP_I & ~trip_prev_ff);
  wire         step_zero;
  wire         wait_zero;
  wire         emerg_req;
  wire         in_emerg;

  // Any of the five terminals coded for emergency run
  always @* begin
    term_hit = 1'b0;
    for (k = 0; k < `FMO_NUM_TERM; k = k + 1)
      if (TERM_IN_I[k] && func_ff[k*6 +: 6] == `FMO_FUNC_EMERG)
        term_hit = 1'b1;
  end

  assign emerg_req = (sel_full | sel_test) & term_hit;
  assign in_emerg  = (state_ff == ST_RUN) | (state_ff == ST_WAIT);

  // Ramp step timer, reloaded on each frequency step
  fmo_down_counter #(.W(16)) u_step (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .load_i  (step_zero),
    .value_i ((state_ff == ST_RAMPD) ? decel_time_ff : accel_time_ff),
    .zero_o  (step_zero)
  );

  // Restart wait timer, held loaded outside ST_WAIT and counting down in it
  fmo_down_counter #(.W(16)) u_wait (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .load_i  (state_ff != ST_WAIT),
    .value_i (restart_wait_time_ff),
    .zero_o  (wait_zero)
  );

  // Sequencer: run, restart wait, hard stop, ramp down
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (emerg_req && !crit)
          nxt_state = ST_RUN;
      ST_RUN:
        if (crit)
          nxt_state = ST_STOP;
        else if (!emerg_req)
          nxt_state = ST_RAMPD;
        else if (major && sel_full)
          nxt_state = ST_WAIT;
      ST_WAIT:
        if (crit)
          nxt_state = ST_STOP;
        else if (!emerg_req)
          nxt_state = ST_RAMPD;
        else if (wait_zero)
          nxt_state = ST_RUN;
      ST_STOP:
        if (!emerg_req && !crit)
          nxt_state = ST_IDLE;
      ST_RAMPD:
        if (emerg_req && !crit)
          nxt_state = ST_RUN;
        else if (crit || ramp_freq_ff == `FMO_FREQ_RST)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // Ramp towards target one unit per step period
  always @* begin
    nxt_ramp_freq = ramp_freq_ff;
    if (state_ff == ST_STOP || state_ff == ST_WAIT || crit)
      nxt_ramp_freq = `FMO_FREQ_RST;
    else if (step_zero) begin
      if (state_ff == ST_RUN && ramp_freq_ff < freq_set_ff)
        nxt_ramp_freq = ramp_freq_ff + 6'h01;
      else if (state_ff == ST_RUN && ramp_freq_ff > freq_set_ff)
        nxt_ramp_freq = ramp_freq_ff - 6'h01;
      else if (state_ff == ST_RAMPD && ramp_freq_ff != `FMO_FREQ_RST)
        nxt_ramp_freq = ramp_freq_ff - 6'h01;
    end
  end

  // Read mux, unmapped words read as zero
  always @* begin
    nxt_rd = 32'h0000_0000;
    case (reg_idx)
      `FMO_REG_MODE:   nxt_rd = {30'h0, mode_ff};
      `FMO_REG_FREQ:   nxt_rd = {26'h0, freq_set_ff};
      `FMO_REG_DIR:    nxt_rd = {31'h0, dir_set_ff};
      `FMO_REG_COUNT:  nxt_rd = count_ff;
      `FMO_REG_FUNC:   nxt_rd = {2'h0, func_ff};
      `FMO_REG_RAMP:   nxt_rd = {decel_time_ff, accel_time_ff};
      `FMO_REG_WAIT:   nxt_rd = {16'h0, restart_wait_time_ff};
      `FMO_REG_STATUS: nxt_rd = {21'h0, ramp_freq_ff, state_ff};
      default:         nxt_rd = 32'h0000_0000;
    endcase
  end

  // Bus slave: ack registered one cycle after strobe, every address acked
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else if (CE_I) begin
      ACK_O <= CYC_I & STB_I & ~ACK_O;
      DAT_O <= nxt_rd;
    end
  end

  // Settings written by software; out-of-range frequency and direction words are refused, and mode code 3 in the low two bits is refused
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_ff              <= `FMO_MODE_OFF;
      freq_set_ff          <= `FMO_FREQ_RST;
      dir_set_ff           <= `FMO_DIR_RST;
      func_ff              <= 30'h0000_0000;
      accel_time_ff        <= `FMO_RAMP_RST;
      decel_time_ff        <= `FMO_RAMP_RST;
      restart_wait_time_ff <= `FMO_WAIT_RST;
    end else if (CE_I && wr_req && SEL_I[0]) begin
      case (reg_idx)
        `FMO_REG_MODE:
          if (DAT_I[1:0] <= `FMO_MODE_FULL)
            mode_ff <= DAT_I[1:0];
        `FMO_REG_FREQ:
          if (DAT_I[31:6] == 26'h0 && DAT_I[5:0] <= `FMO_FREQ_MAX)
            freq_set_ff <= DAT_I[5:0];
        `FMO_REG_DIR:
          if (DAT_I[31:1] == 31'h0)
            dir_set_ff <= DAT_I[0];
        `FMO_REG_FUNC:
          func_ff <= DAT_I[29:0];
        `FMO_REG_RAMP: begin
          accel_time_ff <= DAT_I[15:0];
          decel_time_ff <= DAT_I[31:16];
        end
        `FMO_REG_WAIT:
          restart_wait_time_ff <= DAT_I[15:0];
        default: ;
      endcase
    end
  end

  // Operation counter, counts full runs only, no bus write path
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      count_ff <= 32'h0000_0000;
      armed_ff <= 1'b0;
    end else if (CE_I) begin
      armed_ff <= emerg_req;
      if (emerg_req && !armed_ff && sel_full)
        count_ff <= count_ff + 32'h0000_0001;
    end
  end

  // Sequencer registers and drive outputs
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff       <= ST_IDLE;
      ramp_freq_ff   <= `FMO_FREQ_RST;
      trip_prev_ff   <= {`FMO_TRIP_W{1'b0}};
      FREQ_REF_O     <= `FMO_FREQ_RST;
      DIR_O          <= `FMO_DIR_RST;
      RUN_O          <= 1'b0;
      TRIP_RELAY_O   <= 1'b0;
      TRIP_LOG_O     <= 1'b0;
      FAULT_RESET_O  <= 1'b0;
      EMERG_ACTIVE_O <= 1'b0;
    end else if (CE_I) begin
      state_ff     <= nxt_state;
      ramp_freq_ff <= nxt_ramp_freq;
      trip_prev_ff <= TRIP_I;
      // History logs every new trip, ignored or not
      TRIP_LOG_O   <= new_trip;
      if (in_emerg || state_ff == ST_RAMPD) begin
        FREQ_REF_O <= ramp_freq_ff;
        DIR_O      <= dir_set_ff;
        RUN_O      <= (state_ff != ST_WAIT);
        // Minor trips never reach the relay here; major only in test
        TRIP_RELAY_O <= crit | (major & sel_test);
      end else if (state_ff == ST_STOP) begin
        FREQ_REF_O   <= `FMO_FREQ_RST;
        RUN_O        <= 1'b0;
        TRIP_RELAY_O <= 1'b1;
      end else begin
        // Normal drive behaviour, all trips stop and indicate
        FREQ_REF_O   <= NORMAL_FREQ_I;
        DIR_O        <= 1'b0;
        RUN_O        <= NORMAL_RUN_I & ~(minor | major | crit);
        TRIP_RELAY_O <= minor | major | crit;
      end
      // Reset pulse on entering each restart wait
      FAULT_RESET_O  <= (state_ff == ST_RUN) && (nxt_state == ST_WAIT);
      EMERG_ACTIVE_O <= in_emerg;
    end
  end
endmodule

/* File: verif/fmo_field_model.sv */
/*
 * Field side model: emergency terminal contacts and trip sources.
 * Assumes bench commands that change just after the rising edge.
 */
`timescale 1ns/1ps
module fmo_field_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [4:0]  term_set_i,
  input  wire [15:0] trip_set_i,
  output reg  [4:0]  term_o,
  output reg  [15:0] trip_o
);
  // Contacts move on the edge only, like a debounced input stage
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      term_o <= 5'h00;
      trip_o <= 16'h0000;
    end else begin
      term_o <= term_set_i;
      trip_o <= trip_set_i;
    end
  end
endmodule

/* File: verif/fmo_fire_override_tb.sv */
/*
 * Self-checking bench for the emergency run override block.
 * Assumes the field model and checker beside the design.
 */
`timescale 1ns/1ps
`include "fmo_defs.vh"
module fmo_fire_override_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         we = 1'b0;
  reg         stb = 1'b0;
  reg         cyc = 1'b0;
  reg         nrun = 1'b0;
  reg  [31:0] adr = 32'h0;
  reg  [31:0] wd = 32'h0;
  reg  [31:0] q;
  reg  [3:0]  sel = 4'h0;
  reg  [5:0]  nfreq = 6'h00;
  reg  [5:0]  ftgt = 6'h00;
  reg  [4:0]  tset = 5'h00;
  reg  [15:0] pset = 16'h0000;
  wire [31:0] rd;
  wire [15:0] trip;
  wire [5:0]  freq;
  wire [4:0]  term;
  wire        ack, dir, run, relay, tlog, frst, emerg;
  wire [5:0]  obs = {freq === ftgt, tlog, frst, relay, run, emerg};
  integer     fails = 0, num_checks = 0, waited, hits, i;
  fmo_field_model fld (.clk_i(clk), .rst_i(rst), .term_set_i(tset),
    .trip_set_i(pset), .term_o(term), .trip_o(trip));
  fmo_fire_override uut (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .ADR_I(adr), .DAT_I(wd), .DAT_O(rd), .WE_I(we), .SEL_I(sel),
    .STB_I(stb), .CYC_I(cyc), .ACK_O(ack), .TERM_IN_I(term),
    .NORMAL_FREQ_I(nfreq), .NORMAL_RUN_I(nrun), .TRIP_I(trip),
    .FREQ_REF_O(freq), .DIR_O(dir), .RUN_O(run), .TRIP_RELAY_O(relay),
    .TRIP_LOG_O(tlog), .FAULT_RESET_O(frst), .EMERG_ACTIVE_O(emerg));
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  // Compare and count
  task chk(input [31:0] s, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Wait for one observed flag, bounded; cycles left in waited
  task upto(input integer k, input v, input integer lim);
    begin
      waited = 0;
      @(posedge clk);
      while (obs[k] !== v) begin
        waited = waited + 1;
        if (waited > lim) begin
          fails = fails + 1;
          close_out;
        end
        @(posedge clk);
      end
    end
  endtask
  // Count cycles a flag is high over a window
  task pulses(input integer k, input integer n);
    begin
      hits = 0;
      repeat (n) begin
        @(posedge clk);
        if (obs[k] === 1'b1)
          hits = hits + 1;
      end
    end
  endtask
  // Classic Wishbone cycle; held until ack is sampled high
  task wb(input [31:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      adr <= a;
      we <= w;
      wd <= d;
      sel <= 4'hf;
      cyc <= 1'b1;
      stb <= 1'b1;
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1) begin
        n = n + 1;
        if (n > 20) begin
          fails = fails + 1;
          close_out;
        end
        @(posedge clk);
      end
      q = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  // Reset values, dropped writes, unmapped place, range edge
  task t_regs;
    begin
      for (i = 0; i < 9; i = i + 1) if (i != 4) begin
        wb(i * 4, 1'b0, 32'h0);
        chk(q, i == 5 ? 32'h00100010 : i == 6 ? 32'h28 :
               i == 7 ? 32'h1 : 32'h0);
      end
      for (i = 0; i < 9; i = i + (i == 3 ? 5 : 1)) begin
        wb(i * 4, 1'b1, i == 0 ? 32'h3 : i == 2 ? 32'h2 : 32'h3d);
        wb(i * 4, 1'b0, 32'h0);
        chk(q, 32'h0);
      end
      wb(32'h4, 1'b1, 32'h3c);
      wb(32'h4, 1'b0, 32'h0);
      chk(q, 32'h3c);
      $display("t_regs done");
    end
  endtask
  // Full mode: start, count, ramp, ignored, retried and fatal trips
  task t_full;
    begin
      wb(32'h10, 1'b1, {14'h0, `FMO_FUNC_EMERG, 12'h0});
      wb(32'h4, 1'b1, 32'h5);
      wb(32'h8, 1'b1, 32'h1);
      wb(32'h14, 1'b1, 32'h00030002);
      wb(32'h18, 1'b1, 32'h8);
      wb(32'h0, 1'b1, 32'h2);
      tset <= 5'h01;
      pulses(0, 30);
      chk(hits, 0);
      tset <= 5'h04;
      upto(0, 1'b1, 10);
      chk(dir, 1'b1);
      ftgt = 6'h05;
      upto(5, 1'b1, 40);
      chk(waited >= 10 && waited <= 18, 1);
      wb(32'hc, 1'b0, 32'h0);
      chk(q, 32'h1);
      nfreq <= 6'h14;
      nrun <= 1'b1;
      pset <= 16'h0001;
      pulses(4, 20);
      chk(hits, 1);
      chk({relay, run, freq}, {2'b01, 6'h05});
      pset <= 16'h1000;
      pulses(3, 60);
      chk(hits >= 4, 1);
      pset <= 16'h0000;
      nrun <= 1'b0;
      upto(1, 1'b1, 30);
      pset <= 16'h4000;
      upto(1, 1'b0, 5);
      chk(relay, 1'b1);
      pset <= 16'h0000;
      tset <= 5'h00;
      upto(0, 1'b0, 100);
      chk(freq, 6'h00);
      $display("t_full done");
    end
  endtask
  // Test mode: runs, no restart, count kept
  task t_test;
    begin
      wb(32'h0, 1'b1, 32'h1);
      tset <= 5'h04;
      upto(0, 1'b1, 10);
      pset <= 16'h2000;
      pulses(3, 40);
      chk(hits, 0);
      wb(32'hc, 1'b0, 32'h0);
      chk(q, 32'h1);
      pset <= 16'h0000;
      tset <= 5'h00;
      upto(0, 1'b0, 100);
      // Ramp down to zero before the next mode is chosen
      ftgt = 6'h00;
      upto(5, 1'b1, 60);
      chk(freq, 6'h00);
      repeat (3) @(posedge clk);
      chk(run, 1'b0);
      $display("t_test done");
    end
  endtask
  // Mode off: terminal ignored, minor trip trips normally
  task t_off;
    begin
      wb(32'h0, 1'b1, 32'h0);
      tset <= 5'h04;
      pset <= 16'h0001;
      pulses(0, 20);
      chk({hits, relay}, {32'h0, 1'b1});
      chk(freq, 6'h14);
      pset <= 16'h0000;
      tset <= 5'h00;
      $display("t_off done");
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_full;
    t_test;
    t_off;
    close_out;
  end
endmodule

/* File: verif/fmo_props.sv */
/*
 * Port checker for the emergency run override block.
 * Assumes binding to fmo_fire_override on its single clock.
 */
`timescale 1ns/1ps
`include "fmo_defs.vh"
module fmo_props (
  input wire                   SYS_CLK_I,
  input wire                   RST_I,
  input wire                   CE_I,
  input wire [31:0]            ADR_I,
  input wire [31:0]            DAT_I,
  input wire                   WE_I,
  input wire [3:0]             SEL_I,
  input wire                   STB_I,
  input wire                   CYC_I,
  input wire                   ACK_O,
  input wire [4:0]             TERM_IN_I,
  input wire [`FMO_TRIP_W-1:0] TRIP_I,
  input wire [5:0]             FREQ_REF_O,
  input wire                   RUN_O,
  input wire                   TRIP_RELAY_O,
  input wire                   TRIP_LOG_O,
  input wire                   FAULT_RESET_O,
  input wire                   EMERG_ACTIVE_O
);
  reg [15:0] wait_ff;
  reg [15:0] gap_ff;
  reg        seen_ff;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // Shadow of the wait setting, and cycles since the last retry
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wait_ff <= `FMO_WAIT_RST;
      gap_ff  <= 16'h0000;
      seen_ff <= 1'b0;
    end else begin
      if (CYC_I && STB_I && WE_I && ACK_O && SEL_I[0] &&
          ADR_I[`FMO_ADDR_MSB:`FMO_ADDR_LSB] == `FMO_REG_WAIT)
        wait_ff <= DAT_I[15:0];
      if (FAULT_RESET_O)
        gap_ff <= 16'h0000;
      else if (gap_ff != 16'hfff0)
        gap_ff <= gap_ff + 16'h0001;  // Saturates, no wrap
      if (FAULT_RESET_O)
        seen_ff <= 1'b1;
    end
  end
  chk_ack_follows: assert property (CYC_I && STB_I && CE_I && !ACK_O
    |=> ACK_O) else $error("ack missing after request");
  chk_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  chk_log_on_rise: assert property (CE_I &&
    (TRIP_I & ~$past(TRIP_I)) != 16'h0000 |-> ##[1:2] TRIP_LOG_O)
    else $error("trip not logged");
  chk_relay_quiet: assert property (EMERG_ACTIVE_O &&
    TRIP_I[15:12] == 4'h0 && !TRIP_RELAY_O |=> !TRIP_RELAY_O)
    else $error("relay raised by ignored trip");
  chk_crit_stops_run: assert property (TRIP_I[15:14] != 2'b00
    |-> ##[1:3] (!RUN_O && TRIP_RELAY_O))
    else $error("critical trip did not stop");
  chk_retry_gap: assert property (FAULT_RESET_O && seen_ff
    |-> {1'b0, gap_ff} + 17'h00001 >= {1'b0, wait_ff})
    else $error("retry came too soon");
  chk_freq_limit: assert property (EMERG_ACTIVE_O
    |-> FREQ_REF_O <= `FMO_FREQ_MAX)
    else $error("emergency frequency out of range");
  chk_ramp_step: assert property (RUN_O && $past(RUN_O) &&
    EMERG_ACTIVE_O && $past(EMERG_ACTIVE_O)
    |-> FREQ_REF_O == $past(FREQ_REF_O) ||
        FREQ_REF_O == $past(FREQ_REF_O) + 6'h01 ||
        FREQ_REF_O == $past(FREQ_REF_O) - 6'h01)
    else $error("frequency jumped");
  chk_emerg_needs_term: assert property ($rose(EMERG_ACTIVE_O)
    |-> ($past(TERM_IN_I, 1) | $past(TERM_IN_I, 2)) != 5'h00)
    else $error("emergency run without terminal");
endmodule
bind fmo_fire_override fmo_props u_props (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .CE_I(CE_I), .ADR_I(ADR_I),
  .DAT_I(DAT_I), .WE_I(WE_I), .SEL_I(SEL_I), .STB_I(STB_I),
  .CYC_I(CYC_I), .ACK_O(ACK_O), .TERM_IN_I(TERM_IN_I),
  .TRIP_I(TRIP_I), .FREQ_REF_O(FREQ_REF_O), .RUN_O(RUN_O),
  .TRIP_RELAY_O(TRIP_RELAY_O), .TRIP_LOG_O(TRIP_LOG_O),
  .FAULT_RESET_O(FAULT_RESET_O), .EMERG_ACTIVE_O(EMERG_ACTIVE_O));
